// [core/sss_pkg.sv]
// shared constants and types for the subtract, swap and sleep execution unit
// How it works
// - literal minus accumulator, difference written back into the accumulator
// - carry and half borrow set unless accumulator or its low nibble is larger
// - power-down clears power-down status and sets time-out status, both active low
// - power-down clears watchdog counter and its prescaler
// - power-down enters sleep with the main oscillator halted
// - file register minus accumulator, file address 0 to 127
// - file minus accumulator result to accumulator if dest 0, file if 1
// - with borrow: file minus accumulator minus inverted carry; updates carry, half, zero
// - with borrow result to accumulator if dest 0, file if 1
// - nibble exchange swaps file halves, no status flag changes
// - nibble exchange result to accumulator if dest 0, file if 1
package sss_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;
  localparam int PRESC_W = 8;

  // ==========================================================================
  // reset values
  localparam logic [7:0] ACC_RST        = 8'h00;
  localparam logic [7:0] WDT_CLEAR      = 8'h00;
  localparam logic [7:0] PRESC_CLEAR    = 8'h00;
  localparam logic       CARRY_RST      = 1'b0;
  localparam logic       HALF_RST       = 1'b0;
  localparam logic       ZERO_RST       = 1'b0;
  localparam logic       TIMEOUT_N_RST  = 1'b1;
  localparam logic       PWRDOWN_N_RST  = 1'b1;

  // ==========================================================================
  // destination select
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // ==========================================================================
  // operations
  typedef enum logic [2:0] {
    SSS_OP_NONE,
    SSS_OP_LITERAL_MINUS_ACC,
    SSS_OP_FILE_MINUS_ACC,
    SSS_OP_FILE_MINUS_ACC_BORROW,
    SSS_OP_NIBBLE_EXCHANGE,
    SSS_OP_POWER_DOWN
  } sss_op_e;

endpackage : sss_pkg

// [core/sss_exec.sv]
// execution unit for subtract, nibble exchange and power-down instructions
`timescale 1ns/100ps
module sss_exec (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // instruction request
  input  wire logic                 op_valid,
  input  wire sss_pkg::sss_op_e     op_code,
  input  wire logic [7:0]           op_literal,
  input  wire logic [6:0]           op_file_addr,
  input  wire logic                 op_dest,
  input  wire logic [7:0]           file_rd_data,
  // wake-up from sleep
  input  wire logic                 wake,
  // file register write
  output logic                      file_wr_en,
  output logic [6:0]                file_wr_addr,
  output logic [7:0]                file_wr_data,
  // accumulator and status
  output logic [7:0]                acc,
  output logic                      carry,
  output logic                      half_borrow_flag,
  output logic                      zero,
  output logic                      timeout_status_n,
  output logic                      powerdown_status_n,
  // watchdog and power state
  output logic [7:0]                watchdog_counter,
  output logic [7:0]                watchdog_prescaler,
  output logic                      sleeping,
  output logic                      osc_run
);

  // ==========================================================================
  // subtraction: returns {carry, half borrow flag, difference}
  function automatic logic [9:0] sub_calc(input logic [7:0] a, input logic [7:0] w, input logic b);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} - {1'b0, w} - {8'h00, b};
    low  = {1'b0, a[3:0]} - {1'b0, w[3:0]} - {4'h0, b};
    sub_calc = {~full[8], ~low[4], full[7:0]};
  endfunction : sub_calc

  // ==========================================================================
  // decode
  logic       take;
  logic       is_sub;
  logic [7:0] minuend;
  logic       borrow_in;
  logic [9:0] sub_res;
  logic [7:0] next_result;
  logic       to_file;
  logic       is_swap;

  // no instruction runs while the oscillator is halted
  assign take = op_valid && !sleeping;

  // decode only; the result mux sits outside so this process never reads its own products
  always_comb begin
    is_sub      = 1'b0;
    is_swap     = 1'b0;
    minuend     = file_rd_data;
    borrow_in   = 1'b0;
    to_file     = 1'b0;
    case (op_code)
      sss_pkg::SSS_OP_LITERAL_MINUS_ACC: begin
        is_sub  = 1'b1;
        minuend = op_literal;
      end
      sss_pkg::SSS_OP_FILE_MINUS_ACC: begin
        is_sub  = 1'b1;
        to_file = (op_dest == sss_pkg::DEST_FILE);
      end
      sss_pkg::SSS_OP_FILE_MINUS_ACC_BORROW: begin
        is_sub    = 1'b1;
        borrow_in = ~carry;
        to_file   = (op_dest == sss_pkg::DEST_FILE);
      end
      sss_pkg::SSS_OP_NIBBLE_EXCHANGE: begin
        is_swap = 1'b1;
        to_file = (op_dest == sss_pkg::DEST_FILE);
      end
      default: begin
        is_sub = 1'b0;
      end
    endcase
  end

  assign sub_res = sub_calc(minuend, acc, borrow_in);

  assign next_result = is_swap ? {file_rd_data[3:0], file_rd_data[7:4]} : sub_res[7:0];

  logic writes_result;
  assign writes_result = take && (is_sub || is_swap);

  // ==========================================================================
  // accumulator
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc <= sss_pkg::ACC_RST;
    end else if (writes_result && !to_file) begin
      acc <= next_result;
    end
  end

  // ==========================================================================
  // file write port, one-cycle strobe
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      file_wr_en   <= 1'b0;
      file_wr_addr <= 7'h00;
      file_wr_data <= 8'h00;
    end else begin
      file_wr_en <= writes_result && to_file;
      if (writes_result && to_file) begin
        file_wr_addr <= op_file_addr;
        file_wr_data <= next_result;
      end
    end
  end

  // ==========================================================================
  // arithmetic flags; exchange leaves them alone
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      carry            <= sss_pkg::CARRY_RST;
      half_borrow_flag <= sss_pkg::HALF_RST;
      zero             <= sss_pkg::ZERO_RST;
    end else if (take && is_sub) begin
      carry            <= sub_res[9];
      half_borrow_flag <= sub_res[8];
      zero             <= (sub_res[7:0] == 8'h00);
    end
  end

  // ==========================================================================
  // power-down status bits
  logic pd_go;
  assign pd_go = take && (op_code == sss_pkg::SSS_OP_POWER_DOWN);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      timeout_status_n   <= sss_pkg::TIMEOUT_N_RST;
      powerdown_status_n <= sss_pkg::PWRDOWN_N_RST;
    end else if (pd_go) begin
      timeout_status_n   <= 1'b1;
      powerdown_status_n <= 1'b0;
    end
  end

  // ==========================================================================
  // watchdog: prescaler ticks while awake, counter bumps on prescaler wrap
  // sleep freezes both here; a low-power watchdog oscillator is outside this unit
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_prescaler <= sss_pkg::PRESC_CLEAR;
      watchdog_counter   <= sss_pkg::WDT_CLEAR;
    end else if (pd_go) begin
      watchdog_prescaler <= sss_pkg::PRESC_CLEAR;
      watchdog_counter   <= sss_pkg::WDT_CLEAR;
    end else if (!sleeping) begin
      watchdog_prescaler <= watchdog_prescaler + 8'h01;
      if (watchdog_prescaler == 8'hFF) begin
        watchdog_counter <= watchdog_counter + 8'h01;
      end
    end
  end

  // ==========================================================================
  // sleep state and oscillator run
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleeping <= 1'b0;
      osc_run  <= 1'b1;
    end else if (pd_go) begin
      sleeping <= 1'b1;
      osc_run  <= 1'b0;
    end else if (sleeping && wake) begin
      sleeping <= 1'b0;
      osc_run  <= 1'b1;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_literal_result: assert property (
    take && op_code == sss_pkg::SSS_OP_LITERAL_MINUS_ACC |=>
      acc == 8'($past(op_literal) - $past(acc)) && !file_wr_en)
    else $error("literal minus acc result wrong");

  a_carry_compare: assert property (
    take && (op_code == sss_pkg::SSS_OP_LITERAL_MINUS_ACC || op_code == sss_pkg::SSS_OP_FILE_MINUS_ACC) |=>
      carry == ($past(acc) <= $past(minuend)))
    else $error("carry does not follow compare");

  a_half_compare: assert property (
    take && (op_code == sss_pkg::SSS_OP_LITERAL_MINUS_ACC || op_code == sss_pkg::SSS_OP_FILE_MINUS_ACC) |=>
      half_borrow_flag == ($past(acc[3:0]) <= $past(minuend[3:0])))
    else $error("half borrow does not follow nibble compare");

  a_sleep_status: assert property (
    pd_go |=> !powerdown_status_n && timeout_status_n)
    else $error("power-down status bits wrong");

  a_sleep_watchdog: assert property (
    pd_go |=> watchdog_counter == 8'h00 && watchdog_prescaler == 8'h00 ##1 $stable(watchdog_counter))
    else $error("watchdog not cleared by power-down");

  a_sleep_osc: assert property (
    pd_go ##1 !wake |=> sleeping && !osc_run && $stable(acc))
    else $error("oscillator runs after power-down");

  a_file_dest: assert property (
    take && op_code == sss_pkg::SSS_OP_FILE_MINUS_ACC && op_dest |=>
      file_wr_en && file_wr_addr == $past(op_file_addr) &&
      file_wr_data == 8'($past(file_rd_data) - $past(acc)) && $stable(acc))
    else $error("file minus acc not written to file");

  a_borrow_calc: assert property (
    take && op_code == sss_pkg::SSS_OP_FILE_MINUS_ACC_BORROW && !op_dest |=>
      acc == 8'($past(file_rd_data) - $past(acc) - {7'h00, ~$past(carry)}) && !file_wr_en)
    else $error("borrow subtraction result wrong");

  a_swap_result: assert property (
    take && op_code == sss_pkg::SSS_OP_NIBBLE_EXCHANGE && !op_dest |=>
      acc == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])} &&
      $stable(carry) && $stable(half_borrow_flag) && $stable(zero))
    else $error("nibble exchange wrong or flags moved");

  a_zero_flag: assert property (
    take && is_sub |=> zero == (file_wr_en ? file_wr_data == 8'h00 : acc == 8'h00))
    else $error("zero flag wrong");

endmodule : sss_exec

// [verification/tb_subtract_swap_sleep_exec.sv]
// self-checking bench for the subtract, swap and sleep execution unit
`timescale 1ns/100ps
module tb_subtract_swap_sleep_exec;
  // ==========================================================================
  // stimulus and observed signals
  logic             ref_clk      = 1'b0;
  logic             reset_n      = 1'b0;
  logic             op_valid     = 1'b0;
  sss_pkg::sss_op_e op_code      = sss_pkg::SSS_OP_NONE;
  logic [7:0]       op_literal   = 8'h00;
  logic [6:0]       op_file_addr = 7'h00;
  logic             op_dest      = 1'b0;
  logic [7:0]       file_rd_data = 8'h00;
  logic             wake         = 1'b0;
  logic             file_wr_en, carry, half_borrow_flag, zero, timeout_status_n, powerdown_status_n;
  logic             sleeping, osc_run;
  logic [6:0]       file_wr_addr;
  logic [7:0]       file_wr_data, acc, watchdog_counter, watchdog_prescaler;
  int               failures     = 0;
  int               comparisons  = 0;
  logic [7:0]       m_acc        = 8'h00;
  logic             m_c          = 1'b0;
  logic             m_h          = 1'b0;
  logic             m_z          = 1'b0;

`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end

  always #2.5 ref_clk = ~ref_clk;

  sss_exec sss_exec_inst (.ref_clk(ref_clk), .reset_n(reset_n), .op_valid(op_valid), .op_code(op_code),
    .op_literal(op_literal), .op_file_addr(op_file_addr), .op_dest(op_dest), .file_rd_data(file_rd_data),
    .wake(wake), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .acc(acc), .carry(carry), .half_borrow_flag(half_borrow_flag), .zero(zero),
    .timeout_status_n(timeout_status_n), .powerdown_status_n(powerdown_status_n),
    .watchdog_counter(watchdog_counter), .watchdog_prescaler(watchdog_prescaler),
    .sleeping(sleeping), .osc_run(osc_run));

  // ==========================================================================
  // one instruction; entered just after an edge, op_valid left high for back-to-back use
  task automatic run(input sss_pkg::sss_op_e op, input logic [7:0] lit, input logic [7:0] f,
                     input logic [6:0] addr, input logic dest);
    logic [8:0] d;
    logic [4:0] lo;
    logic [7:0] a;
    logic [7:0] r;
    logic       bin;
    logic       to_file;
    logic       is_sub;
    is_sub  = (op == sss_pkg::SSS_OP_LITERAL_MINUS_ACC) || (op == sss_pkg::SSS_OP_FILE_MINUS_ACC) ||
              (op == sss_pkg::SSS_OP_FILE_MINUS_ACC_BORROW);
    a       = (op == sss_pkg::SSS_OP_LITERAL_MINUS_ACC) ? lit : f;
    bin     = (op == sss_pkg::SSS_OP_FILE_MINUS_ACC_BORROW) ? ~m_c : 1'b0;
    d       = {1'b0, a} - {1'b0, m_acc} - {8'h00, bin};
    lo      = {1'b0, a[3:0]} - {1'b0, m_acc[3:0]} - {4'h0, bin};
    r       = (op == sss_pkg::SSS_OP_NIBBLE_EXCHANGE) ? {f[3:0], f[7:4]} : d[7:0];
    to_file = (is_sub || op == sss_pkg::SSS_OP_NIBBLE_EXCHANGE) && op != sss_pkg::SSS_OP_LITERAL_MINUS_ACC && dest;
    op_valid     = 1'b1;
    op_code      = op;
    op_literal   = lit;
    file_rd_data = f;
    op_file_addr = addr;
    op_dest      = dest;
    @(posedge ref_clk);
    #1;
    if (is_sub) begin
      m_c = ~d[8];
      m_h = ~lo[4];
      m_z = (d[7:0] == 8'h00);
    end
    if ((is_sub || op == sss_pkg::SSS_OP_NIBBLE_EXCHANGE) && !to_file) m_acc = r;
    `CHK("acc", m_acc, acc)
    `CHK("carry", m_c, carry)
    `CHK("half_borrow_flag", m_h, half_borrow_flag)
    `CHK("zero", m_z, zero)
    `CHK("file_wr_en", to_file, file_wr_en)
    if (to_file) begin
      `CHK("file_wr_addr", addr, file_wr_addr)
      `CHK("file_wr_data", r, file_wr_data)
    end
  endtask : run

  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // ==========================================================================
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    `CHK("timeout_status_n", 1'b1, timeout_status_n)
    `CHK("osc_run", 1'b1, osc_run)
    // arithmetic, issued back to back; flags carried across calls
    run(sss_pkg::SSS_OP_NIBBLE_EXCHANGE, 8'h00, 8'h50, 7'h00, 1'b0);
    run(sss_pkg::SSS_OP_LITERAL_MINUS_ACC, 8'h03, 8'h00, 7'h00, 1'b1);
    run(sss_pkg::SSS_OP_LITERAL_MINUS_ACC, 8'hFE, 8'h00, 7'h00, 1'b0);
    run(sss_pkg::SSS_OP_FILE_MINUS_ACC, 8'h00, 8'h10, 7'h7F, 1'b1);
    run(sss_pkg::SSS_OP_NIBBLE_EXCHANGE, 8'h00, 8'hA5, 7'h01, 1'b1);
    run(sss_pkg::SSS_OP_NIBBLE_EXCHANGE, 8'h00, 8'h21, 7'h02, 1'b0);
    run(sss_pkg::SSS_OP_FILE_MINUS_ACC, 8'h00, 8'h10, 7'h03, 1'b0);
    run(sss_pkg::SSS_OP_FILE_MINUS_ACC_BORROW, 8'h00, 8'h10, 7'h04, 1'b1);
    run(sss_pkg::SSS_OP_FILE_MINUS_ACC_BORROW, 8'h00, 8'hFF, 7'h05, 1'b0);
    run(sss_pkg::SSS_OP_FILE_MINUS_ACC_BORROW, 8'h00, 8'h05, 7'h06, 1'b0);
    run(sss_pkg::SSS_OP_NONE, 8'h00, 8'h33, 7'h07, 1'b1);
    op_valid = 1'b0;
    $display("test arithmetic done");
    // idle past one prescaler wrap so the clear of both watchdog stages is visible
    repeat (300) @(posedge ref_clk);
    #1;
    `CHK("watchdog_counter running", 1'b1, watchdog_counter != 8'h00)
    run(sss_pkg::SSS_OP_POWER_DOWN, 8'h00, 8'h00, 7'h00, 1'b0);
    `CHK("powerdown_status_n", 1'b0, powerdown_status_n)
    `CHK("timeout_status_n", 1'b1, timeout_status_n)
    `CHK("watchdog_counter", 8'h00, watchdog_counter)
    `CHK("watchdog_prescaler", 8'h00, watchdog_prescaler)
    `CHK("sleeping", 1'b1, sleeping)
    `CHK("osc_run", 1'b0, osc_run)
    // requests while asleep are dropped
    op_code = sss_pkg::SSS_OP_LITERAL_MINUS_ACC;
    op_literal = 8'h55;
    @(posedge ref_clk);
    #1;
    op_valid = 1'b0;
    `CHK("acc asleep", m_acc, acc)
    `CHK("sleeping held", 1'b1, sleeping)
    wake = 1'b1;
    for (int i = 0; i < 8 && sleeping !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    wake = 1'b0;
    if (sleeping !== 1'b0) begin
      failures++;
    end
    `CHK("osc_run woken", 1'b1, osc_run)
    $display("test power-down done");
    end_sim();
  end
endmodule : tb_subtract_swap_sleep_exec
